// file: hpp_pkg.sv
// shared constants and types for the host port strobe and ready logic
package hpp_pkg;
    localparam int hw_w = 16;
    localparam int word_w = 32;
    localparam int fifo_depth = 4;
    localparam int min_strobe_cycles = 2;
    localparam int aux_latency = 3;
    localparam logic [1:0] sel_control = 2'h0;
    localparam logic [1:0] sel_data_autoinc = 2'h1;
    localparam logic [1:0] sel_address = 2'h2;
    localparam logic [1:0] sel_data = 2'h3;
    localparam logic [2:0] aux_cnt_zero = 3'h0;
    typedef enum logic [2:0] {
        hh_idle = 3'b000,
        hh_sel = 3'b001,
        hh_low = 3'b010,
        hh_wait = 3'b011,
        hh_high = 3'b100
    } hpp_host_state_t;
endpackage : hpp_pkg

// file: hpp_if.sv
// pin-level carrier between host and device ends
`timescale 1ns/1ps
interface hpp_if;
    logic port_select_n;
    logic data_strobe_a;
    logic data_strobe_b;
    logic addr_latch_n;
    logic [1:0] access_type_select;
    logic read_write_select;
    logic halfword_identify;
    logic [15:0] host_data_out;
    logic host_data_oe;
    logic [15:0] dev_data_out;
    logic dev_data_oe;
    logic port_ready_n;
    logic [15:0] host_data_bus;
    assign host_data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 16'h0);
    modport device (
        input port_select_n, data_strobe_a, data_strobe_b, addr_latch_n,
        input access_type_select, read_write_select, halfword_identify, host_data_bus,
        output dev_data_out, dev_data_oe, port_ready_n
    );
    modport host (
        output port_select_n, data_strobe_a, data_strobe_b, addr_latch_n,
        output access_type_select, read_write_select, halfword_identify, host_data_out, host_data_oe,
        input host_data_bus, port_ready_n
    );
endinterface : hpp_if

// file: hpp_fifo.sv
// small valid/ready fifo
`timescale 1ns/1ps
module hpp_fifo #(
    parameter int width = 32,
    parameter int depth = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw-1:0] wr_reg;
    logic [aw-1:0] rd_reg;
    logic [aw:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready = cnt_reg != (aw+1)'(depth);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == aw'(depth - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == aw'(depth - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (aw+1)'(push) - (aw+1)'(pop);
        end
    end
endmodule : hpp_fifo

// file: hpp_device.sv
// device end: strobe decode, select capture, ready and data paths
`timescale 1ns/1ps
module hpp_device (
    input wire logic clock,
    input wire logic rstn,
    hpp_if.device port,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [31:0] wr_data,
    output logic [1:0] wr_type,
    output logic rd_req,
    input wire logic [31:0] rd_word,
    output logic rd_autoinc
);
    logic strobe_n;
    logic strobe_d_reg;
    logic fall;
    logic rise;
    logic sel_d_reg;
    logic [1:0] type_reg;
    logic rnw_reg;
    logic hwid_reg;
    logic [15:0] first_reg;
    logic [31:0] rdata_reg;
    logic rd_pend_reg;
    logic busy_reg;
    logic rdy_reg;
    logic oe_reg;
    logic [15:0] dout_reg;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [hpp_pkg::word_w+1:0] fifo_out;
    logic rd_start;
    logic [2:0] aux_cnt_reg;
    logic reset_grp_reg;
    logic [1:0] st_type;
    logic st_rnw;
    logic st_hwid;
    logic is_second_xfer;

    function automatic logic xfer_kind(input logic [1:0] t, input logic rnw);
        xfer_kind = (t == hpp_pkg::sel_data && !rnw) || (t == hpp_pkg::sel_data_autoinc);
    endfunction : xfer_kind

    function automatic logic is_data_type(input logic [1:0] t);
        is_data_type = (t == hpp_pkg::sel_data) || (t == hpp_pkg::sel_data_autoinc);
    endfunction : is_data_type

    assign strobe_n = ~(port.data_strobe_a ^ port.data_strobe_b) | port.port_select_n;
    assign fall = strobe_d_reg && !strobe_n;
    assign rise = !strobe_d_reg && strobe_n;
    // selects from latch when used, else live at strobe fall
    assign st_type = port.addr_latch_n ? port.access_type_select : type_reg;
    assign st_rnw = port.addr_latch_n ? port.read_write_select : rnw_reg;
    assign st_hwid = port.addr_latch_n ? port.halfword_identify : hwid_reg;
    assign is_second_xfer = hwid_reg && xfer_kind(type_reg, rnw_reg);
    assign rd_start = fall && st_rnw && !st_hwid && is_data_type(st_type);

    // strobe delayed to find its edges
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strobe_d_reg <= 1'b1;
        end else begin
            strobe_d_reg <= strobe_n;
        end
    end

    // select delayed to spot its falling edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sel_d_reg <= 1'b1;
        end else begin
            sel_d_reg <= port.port_select_n;
        end
    end

    // select capture while latch is low with strobe high, or on strobe fall
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            type_reg <= hpp_pkg::sel_control;
            rnw_reg <= 1'b0;
            hwid_reg <= 1'b0;
        end else if (!port.addr_latch_n && strobe_n) begin
            type_reg <= port.access_type_select;
            rnw_reg <= port.read_write_select;
            hwid_reg <= port.halfword_identify;
        end else if (fall) begin
            type_reg <= st_type;
            rnw_reg <= st_rnw;
            hwid_reg <= st_hwid;
        end
    end

    // first halfword held until the second arrives
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            first_reg <= '0;
        end else if (rise && !rnw_reg && !hwid_reg) begin
            first_reg <= port.host_data_bus;
        end
    end

    // word and its access type travel together through the fifo
    assign fifo_in_valid = rise && !rnw_reg && hwid_reg && type_reg == hpp_pkg::sel_data;
    hpp_fifo #(.width(hpp_pkg::word_w + 2), .depth(hpp_pkg::fifo_depth)) hpp_fifo_i (
        .clock(clock),
        .rstn(rstn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({type_reg, port.host_data_bus, first_reg}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out)
    );
    assign wr_data = fifo_out[hpp_pkg::word_w-1:0];
    assign wr_type = fifo_out[hpp_pkg::word_w+1:hpp_pkg::word_w];

    // auxiliary channel read request registered one clock after first halfword strobe fall
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_req <= 1'b0;
            rd_autoinc <= 1'b0;
        end else begin
            rd_req <= rd_start;
            if (rd_start) begin
                rd_autoinc <= st_type == hpp_pkg::sel_data_autoinc;
            end
        end
    end

    // pending read counts down the channel latency
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_pend_reg <= 1'b0;
            aux_cnt_reg <= hpp_pkg::aux_cnt_zero;
        end else if (rd_start) begin
            rd_pend_reg <= 1'b1;
            aux_cnt_reg <= 3'(hpp_pkg::aux_latency);
        end else if (rd_pend_reg) begin
            if (aux_cnt_reg == hpp_pkg::aux_cnt_zero) begin
                rd_pend_reg <= 1'b0;
            end else begin
                aux_cnt_reg <= aux_cnt_reg - 3'h1;
            end
        end
    end

    // read word loaded when the channel answers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else if (rd_pend_reg && !rd_start && aux_cnt_reg == hpp_pkg::aux_cnt_zero) begin
            rdata_reg <= rd_word;
        end
    end

    // post-transfer busy after second halfword of data write or of autoinc read or write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
        end else if (rise && is_second_xfer) begin
            busy_reg <= 1'b1;
        end else if (busy_reg && fifo_in_ready) begin
            busy_reg <= 1'b0;
        end
    end

    // ready pin, low means ready
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdy_reg <= 1'b0;
        end else if (port.port_select_n) begin
            rdy_reg <= 1'b0;
        end else if (sel_d_reg && busy_reg) begin
            rdy_reg <= 1'b1;
        end else if (rd_pend_reg || (rise && is_second_xfer) || busy_reg) begin
            rdy_reg <= 1'b1;
        end else begin
            rdy_reg <= 1'b0;
        end
    end

    // flag set one clock after reset release, gating the ready pin
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reset_grp_reg <= 1'b0;
        end else begin
            reset_grp_reg <= 1'b1;
        end
    end
    // during reset ready is gated by select: low if select high, else held high
    assign port.port_ready_n = !rstn ? !port.port_select_n : (reset_grp_reg && rdy_reg && !port.port_select_n);

    // bus enable follows the strobe on reads
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            oe_reg <= 1'b0;
        end else if (fall && st_rnw) begin
            oe_reg <= 1'b1;
        end else if (rise) begin
            oe_reg <= 1'b0;
        end
    end

    // halfword of the read word chosen by the identify select
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dout_reg <= '0;
        end else if (oe_reg && !fall && !rise) begin
            dout_reg <= hwid_reg ? rdata_reg[31:16] : rdata_reg[15:0];
        end
    end
    assign port.dev_data_oe = oe_reg;
    assign port.dev_data_out = dout_reg;
endmodule : hpp_device

// file: hpp_host.sv
// host end: issues two-halfword accesses honouring ready and strobe widths
`timescale 1ns/1ps
module hpp_host (
    input wire logic clock,
    input wire logic rstn,
    hpp_if.host port,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_type,
    input wire logic cmd_read,
    input wire logic [31:0] cmd_wdata,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata
);
    hpp_pkg::hpp_host_state_t st_reg;
    logic [1:0] cnt_reg;
    logic half_reg;
    logic [1:0] type_reg;
    logic read_reg;
    logic [31:0] wdata_reg;
    logic strobe_reg;
    assign cmd_ready = st_reg == hpp_pkg::hh_idle;
    assign port.port_select_n = st_reg == hpp_pkg::hh_idle;
    assign port.data_strobe_a = strobe_reg;
    assign port.data_strobe_b = 1'b1;
    assign port.addr_latch_n = 1'b1;
    assign port.access_type_select = type_reg;
    assign port.read_write_select = read_reg;
    assign port.halfword_identify = half_reg;
    assign port.host_data_out = half_reg ? wdata_reg[31:16] : wdata_reg[15:0];
    assign port.host_data_oe = !read_reg && st_reg != hpp_pkg::hh_idle;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg <= hpp_pkg::hh_idle;
            cnt_reg <= '0;
            half_reg <= 1'b0;
            type_reg <= hpp_pkg::sel_control;
            read_reg <= 1'b0;
            wdata_reg <= '0;
            strobe_reg <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (st_reg)
                hpp_pkg::hh_idle: begin
                    if (cmd_valid) begin
                        type_reg <= cmd_type;
                        read_reg <= cmd_read;
                        wdata_reg <= cmd_wdata;
                        half_reg <= 1'b0;
                        st_reg <= hpp_pkg::hh_sel;
                    end
                end
                hpp_pkg::hh_sel: begin
                    strobe_reg <= 1'b0;
                    cnt_reg <= '0;
                    st_reg <= hpp_pkg::hh_low;
                end
                hpp_pkg::hh_low: begin
                    if (cnt_reg == 2'(hpp_pkg::min_strobe_cycles - 1)) begin
                        st_reg <= hpp_pkg::hh_wait;
                    end else begin
                        cnt_reg <= cnt_reg + 2'h1;
                    end
                end
                hpp_pkg::hh_wait: begin
                    if (!port.port_ready_n) begin
                        strobe_reg <= 1'b1;
                        cnt_reg <= '0;
                        if (half_reg) begin
                            rsp_rdata[31:16] <= port.host_data_bus;
                        end else begin
                            rsp_rdata[15:0] <= port.host_data_bus;
                        end
                        st_reg <= hpp_pkg::hh_high;
                    end
                end
                hpp_pkg::hh_high: begin
                    if (cnt_reg == 2'(hpp_pkg::min_strobe_cycles - 1)) begin
                        if (half_reg) begin
                            rsp_valid <= 1'b1;
                            st_reg <= hpp_pkg::hh_idle;
                        end else begin
                            half_reg <= 1'b1;
                            strobe_reg <= 1'b0;
                            cnt_reg <= '0;
                            st_reg <= hpp_pkg::hh_low;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 2'h1;
                    end
                end
                default: st_reg <= hpp_pkg::hh_idle;
            endcase
        end
    end
endmodule : hpp_host

// file: hpp_assertions.sv
// concurrent checks on the host port wires
`timescale 1ns/1ps
module hpp_assertions (
    input wire logic clock,
    input wire logic rstn,
    input wire logic port_select_n,
    input wire logic data_strobe_a,
    input wire logic data_strobe_b,
    input wire logic [1:0] access_type_select,
    input wire logic read_write_select,
    input wire logic halfword_identify,
    input wire logic dev_data_oe,
    input wire logic port_ready_n
);
    logic strobe_n;
    assign strobe_n = ~(data_strobe_a ^ data_strobe_b) | port_select_n;
    default clocking cb @(posedge clock);
    endclocking
    sequence read_first_fall;
        $fell(strobe_n) && read_write_select && access_type_select == hpp_pkg::sel_data && !halfword_identify;
    endsequence
    sequence write_second_rise;
        $rose(strobe_n) && !port_select_n && $past(halfword_identify) && !$past(read_write_select)
            && $past(access_type_select) == hpp_pkg::sel_data;
    endsequence
    sequence busy_soon;
        ##[1:3] (port_ready_n || port_select_n);
    endsequence
    chk_ready_gated: assert property (disable iff (!rstn) port_select_n |-> !port_ready_n)
        else $error("ready high while port not selected");
    chk_reset_level: assert property (!rstn |-> port_ready_n == !port_select_n)
        else $error("ready level wrong during reset");
    chk_ctrl_quiet: assert property (disable iff (!rstn)
        !strobe_n && !access_type_select[0] && !port_ready_n |=> !port_ready_n)
        else $error("control or address access raised ready");
    chk_strobe_hold: assert property (disable iff (!rstn)
        $rose(strobe_n) && !port_select_n |-> !$past(port_ready_n))
        else $error("strobe released before ready");
    chk_strobe_width: assert property (disable iff (!rstn) $fell(strobe_n) |=> !strobe_n)
        else $error("strobe low too short");
    chk_oe_on: assert property (disable iff (!rstn)
        $fell(strobe_n) && read_write_select |-> ##[1:3] dev_data_oe)
        else $error("read data not driven");
    chk_oe_off: assert property (disable iff (!rstn) $rose(strobe_n) |-> ##[1:3] !dev_data_oe)
        else $error("data bus not released");
    chk_read_busy: assert property (disable iff (!rstn) read_first_fall |-> busy_soon)
        else $error("data read did not raise ready");
    chk_write_busy: assert property (disable iff (!rstn) write_second_rise |-> busy_soon)
        else $error("second halfword write did not raise ready");
    chk_busy_bound: assert property (disable iff (!rstn) $rose(port_ready_n) |-> ##[1:1000] !port_ready_n)
        else $error("ready stuck high");
endmodule : hpp_assertions

// file: host_port_strobe_ready_logic_bench.sv
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module host_port_strobe_ready_logic_bench;
    logic clock;
    logic rstn;
    logic cmd_valid;
    logic cmd_ready;
    logic [1:0] cmd_type;
    logic cmd_read;
    logic [31:0] cmd_wdata;
    logic rsp_valid;
    logic [31:0] rsp_rdata;
    logic wr_valid;
    logic wr_ready;
    logic [31:0] wr_data;
    logic [1:0] wr_type;
    logic rd_req;
    logic [31:0] rd_word;
    logic rd_autoinc;
    logic stall;
    logic cur_ai;
    logic [32:0] rsp_q[$];
    logic [31:0] wr_q[$];
    logic [32:0] re;
    integer seed;
    int n_fail;
    int n_checks;
    int sent;
    int rsp_cnt;
    int cycles;
    hpp_if hpp_if_i();
    hpp_host hpp_host_i(.clock(clock), .rstn(rstn), .port(hpp_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_type(cmd_type), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    hpp_device hpp_device_i(.clock(clock), .rstn(rstn), .port(hpp_if_i), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_type(wr_type), .rd_req(rd_req), .rd_word(rd_word), .rd_autoinc(rd_autoinc));
    hpp_assertions hpp_assertions_i(.clock(clock), .rstn(rstn), .port_select_n(hpp_if_i.port_select_n),
        .data_strobe_a(hpp_if_i.data_strobe_a), .data_strobe_b(hpp_if_i.data_strobe_b),
        .access_type_select(hpp_if_i.access_type_select), .read_write_select(hpp_if_i.read_write_select),
        .halfword_identify(hpp_if_i.halfword_identify), .dev_data_oe(hpp_if_i.dev_data_oe),
        .port_ready_n(hpp_if_i.port_ready_n));
    task automatic end_of_test;
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected word time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected flag time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag
    // one whole word as two halfwords, expectations noted at issue
    task automatic send(input logic [1:0] t, input logic rd, input logic wait_rsp);
        logic [31:0] d;
        d = $random(seed);
        while (cmd_ready !== 1'b1) @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_type <= t;
        cmd_read <= rd;
        cmd_wdata <= d;
        if (rd) rd_word <= d;
        rsp_q.push_back({rd && (t == hpp_pkg::sel_data || t == hpp_pkg::sel_data_autoinc), d});
        if (!rd && t == hpp_pkg::sel_data) wr_q.push_back(d);
        cur_ai = (t == hpp_pkg::sel_data_autoinc);
        sent++;
        @(posedge clock);
        cmd_valid <= 1'b0;
        if (wait_rsp) while (rsp_cnt < sent) @(posedge clock);
    endtask : send
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        wr_ready <= !stall && ($random(seed) % 4 != 0);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    always @(posedge clock) begin
        if (rstn === 1'b1) begin
            if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
                cmp_word(wr_data, (wr_q.size() != 0) ? wr_q.pop_front() : 32'hx);
                cmp_word({30'h0, wr_type}, {30'h0, hpp_pkg::sel_data});
            end
            if (rsp_valid === 1'b1) begin
                re = (rsp_q.size() != 0) ? rsp_q.pop_front() : {1'b1, 32'hx};
                if (re[32]) cmp_word(rsp_rdata, re[31:0]);
                rsp_cnt <= rsp_cnt + 1;
            end
            if (rd_req === 1'b1) cmp_flag(rd_autoinc, cur_ai);
        end
    end
    initial begin
        seed = 84;
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_type = 2'h0;
        cmd_read = 1'b0;
        cmd_wdata = 32'h0;
        wr_ready = 1'b0;
        rd_word = 32'h0;
        stall = 1'b1;
        cur_ai = 1'b0;
        n_fail = 0;
        n_checks = 0;
        sent = 0;
        rsp_cnt = 0;
        cycles = 0;
        repeat (16) @(posedge clock);
        cmp_flag(hpp_if_i.port_ready_n, ~hpp_if_i.port_select_n);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        // fill the fifo while the far side stalls, the next word must wait
        repeat (hpp_pkg::fifo_depth) send(hpp_pkg::sel_data, 1'b0, 1'b1);
        send(hpp_pkg::sel_data, 1'b0, 1'b0);
        repeat (30) @(posedge clock);
        cmp_flag(hpp_if_i.port_ready_n, 1'b1);
        cmp_word(32'(rsp_cnt), 32'(sent - 1));
        stall <= 1'b0;
        while (rsp_cnt < sent) @(posedge clock);
        for (int i = 0; i < 48; i++) send(2'(i), 1'($random(seed)), 1'b1);
        repeat (30) @(posedge clock);
        cmp_word(32'(wr_q.size()), 32'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        cmp_flag(hpp_if_i.port_ready_n, ~hpp_if_i.port_select_n);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        send(hpp_pkg::sel_data, 1'b1, 1'b1);
        send(hpp_pkg::sel_data, 1'b0, 1'b1);
        repeat (30) @(posedge clock);
        cmp_word(32'(wr_q.size()), 32'h0);
        end_of_test();
    end
endmodule : host_port_strobe_ready_logic_bench
